//--- shared/mfp_defines.svh
// Purpose: offsets, field positions, reset values and counts of the pin block
// Assumes: byte-wide register port with an 8-bit address
// Notes: definitions only
`ifndef MFP_DEFINES_SVH
`define MFP_DEFINES_SVH

// ==========================================================
// register offsets
`define MFP_ADDR_ALM0_DATE 8'h0E
`define MFP_ADDR_ALM0_MONTH 8'h0F
`define MFP_ADDR_ALM1_DATE 8'h15
`define MFP_ADDR_ALM1_MONTH 8'h16
`define MFP_ADDR_CONTROL 8'h07
`define MFP_ADDR_IRQ_STATUS 8'h20
`define MFP_ADDR_IRQ_CLEAR 8'h21
`define MFP_ADDR_IRQ_ENABLE 8'h22
`define MFP_ADDR_PIN_STATE 8'h23

// ==========================================================
// control fields
`define MFP_CTRL_OUT 7
`define MFP_CTRL_SQUARE_WAVE_ENABLE 6
`define MFP_CTRL_ALARM1_ENABLE 5
`define MFP_CTRL_ALARM0_ENABLE 4
`define MFP_CTRL_COARSE_TRIM_ENABLE 2
`define MFP_CTRL_FS_HI 1
`define MFP_CTRL_FS_LO 0

// ==========================================================
// match register layout and reset values
`define MFP_DATE_MASK 8'h3F
`define MFP_MONTH_MASK 8'h1F
`define MFP_DATE_RESET 8'h01
`define MFP_MONTH_RESET 8'h01
`define MFP_CTRL_RESET 8'h80

// ==========================================================
// interrupt status bits
`define MFP_IRQ_ALARM 0
`define MFP_IRQ_BK_ENTER 1
`define MFP_IRQ_BK_EXIT 2
`define MFP_IRQ_W 3

// ==========================================================
// half periods of the square wave, in oscillator edges
`define MFP_DIV_FS00 16'h8000
`define MFP_DIV_FS01 16'h0008
`define MFP_DIV_FS10 16'h0004
`define MFP_DIV_FS11 16'h0001
`define MFP_DIV_COARSE 16'h0200

`endif

//--- shared/mfp_pkg.sv
// Purpose: types of the multi-function pin block
// Assumes: nothing
// Notes: all constants live in the defines header
package mfp_pkg;

    // ==========================================================
    // pin function
    typedef enum logic [1:0] {
        MODE_GP,
        MODE_ALARM,
        MODE_SQW
    } mode_t;

    // ==========================================================
    // module states
    typedef struct packed {
        logic [14:0] cnt;
        logic sqw;
    } div_state_t;

    typedef struct packed {
        logic [7:0] value;
    } match_state_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [2:0] irq_status;
        logic [2:0] irq_enable;
        logic [7:0] rdata;
        logic backup_prev;
        logic alarm_prev;
        logic pin_release;
    } top_state_t;

endpackage : mfp_pkg

//--- logic/bcd_match_reg.sv
// Purpose: one alarm compare register with unimplemented upper bits
// Assumes: write strobe is already decoded for this register
// Notes: bits outside the mask never store and read as zero
`include "mfp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module bcd_match_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h01,
    parameter logic [7:0] WRITE_MASK = 8'hFF
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // write port
    input wire logic wr_en_i,
    input wire logic [7:0] wdata_i,
    // stored value
    output logic [7:0] value_o
);

    mfp_pkg::match_state_t q, d;

    always_comb begin
        d = q;
        if (wr_en_i) begin
            d.value = wdata_i & WRITE_MASK;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            q <= '{value: RESET_VALUE & WRITE_MASK};
        end else begin
            q <= d;
        end
    end

    assign value_o = q.value;

    // ==========================================================
    // checks
    upper_zero_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (value_o & ~WRITE_MASK) == 8'h00)
        else $error("unimplemented match bits are set");

endmodule : bcd_match_reg

`default_nettype wire

//--- logic/sqw_divider.sv
// Purpose: square wave postscaler on the oscillator edge enable
// Assumes: osc_edge_i pulses once per edge of the 32.768 kHz clock
// Notes: output low and counter cleared while not running
`include "mfp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sqw_divider #(
    parameter logic [15:0] ONE_HZ_HALF = `MFP_DIV_FS00
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // control
    input wire logic osc_edge_i,
    input wire logic run_i,
    input wire logic coarse_i,
    input wire logic [1:0] freq_sel_i,
    // square wave
    output logic sqw_o
);

    mfp_pkg::div_state_t q, d;
    logic [15:0] half;
    logic last;

    always_comb begin
        half = `MFP_DIV_COARSE;
        if (!coarse_i) begin
            unique case (freq_sel_i)
                2'b00: half = ONE_HZ_HALF;
                2'b01: half = `MFP_DIV_FS01;
                2'b10: half = `MFP_DIV_FS10;
                2'b11: half = `MFP_DIV_FS11;
            endcase
        end
        last = ({1'b0, q.cnt} + 16'h0001) >= half;
        d = q;
        if (!run_i) begin
            d = '0;
        end else if (osc_edge_i) begin
            d.cnt = last ? 15'h0000 : q.cnt + 15'h0001;
            d.sqw = last ? ~q.sqw : q.sqw;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sqw_o = q.sqw;

    // ==========================================================
    // checks
    full_rate_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        run_i && !coarse_i && freq_sel_i == 2'b11 && osc_edge_i |=> sqw_o != $past(sqw_o))
        else $error("1:1 rate did not toggle on an edge");
    coarse_rate_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        run_i && coarse_i && osc_edge_i |=> (sqw_o != $past(sqw_o)) == ($past(q.cnt) == 15'h01FF))
        else $error("coarse trim wave not on 512 edge half period");

endmodule : sqw_divider

`default_nettype wire

//--- logic/mfp_output_mux.sv
// Purpose: alarm date/month compare registers and the multi-function pin mux
// Assumes: register port strobes are one cycle and never both at once
// Notes: pin level is registered, so it follows its cause by one cycle
//
// Contract
// - there is a date compare register for alarm 0 and one for alarm 1, at separate addresses.
// - there is a month compare register for alarm 0 and one for alarm 1, at separate addresses.
// - a date register keeps the tens digit in bits 5-4 and the ones digit in bits 3-0.
// - a month register keeps the tens digit in bit 4 and the ones digit in bits 3-0.
// - the unused top bits of date and month registers read back as zero.
// - square wave wins over alarms, alarms win over the general-purpose level.
// - on backup power only the alarm function may drive the pin.
// - the pin is only pulled low or released, and the far side supplies the pull-up.
// - the square wave divides the oscillator by 32768, 8, 4 or 1 per the select code.
// - with one alarm enabled the pin is its flag, inverted when polarity is low.
// - with both alarms enabled the pin is flag OR, or inverted flag AND at low polarity.
//
// Design decision made here: the address-and-strobe port.
`include "mfp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module mfp_output_mux #(
    parameter logic [15:0] ONE_HZ_HALF = `MFP_DIV_FS00
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // timekeeping side
    input wire logic osc_edge_i,
    input wire logic on_backup_i,
    input wire logic alarm0_flag_i,
    input wire logic alarm1_flag_i,
    input wire logic alarm_polarity_i,
    // compare values for the alarm matcher
    output logic [7:0] alarm0_date_o,
    output logic [7:0] alarm0_month_o,
    output logic [7:0] alarm1_date_o,
    output logic [7:0] alarm1_month_o,
    // multi-function pin, open drain
    input wire logic multi_function_pin_i,
    output logic multi_function_pin_o,
    output logic multi_function_pin_oe_n_o,
    // interrupt
    output logic irq_o
);

    mfp_pkg::top_state_t q, d;
    mfp_pkg::mode_t mode;
    logic square_wave_enable;
    logic alarm0_enable;
    logic alarm1_enable;
    logic coarse_trim_enable;
    logic gp_level;
    logic [1:0] square_wave_freq_select;
    logic sqw;
    logic alarm_level;
    logic alarm_asserted;
    logic level;
    logic [2:0] events;
    logic [7:0] read_mux;

    // the pin starts released, in line with the level bit resetting to one
    localparam mfp_pkg::top_state_t RESET_STATE = '{
        ctrl: `MFP_CTRL_RESET,
        pin_release: 1'b1,
        default: '0};

    // ==========================================================
    // alarm compare registers
    bcd_match_reg #(
        .RESET_VALUE(`MFP_DATE_RESET),
        .WRITE_MASK(`MFP_DATE_MASK)
    ) u_alm0_date (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(wr_i && addr_i == `MFP_ADDR_ALM0_DATE),
        .wdata_i(wdata_i),
        .value_o(alarm0_date_o)
    );
    bcd_match_reg #(
        .RESET_VALUE(`MFP_MONTH_RESET),
        .WRITE_MASK(`MFP_MONTH_MASK)
    ) u_alm0_month (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(wr_i && addr_i == `MFP_ADDR_ALM0_MONTH),
        .wdata_i(wdata_i),
        .value_o(alarm0_month_o)
    );
    bcd_match_reg #(
        .RESET_VALUE(`MFP_DATE_RESET),
        .WRITE_MASK(`MFP_DATE_MASK)
    ) u_alm1_date (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(wr_i && addr_i == `MFP_ADDR_ALM1_DATE),
        .wdata_i(wdata_i),
        .value_o(alarm1_date_o)
    );
    bcd_match_reg #(
        .RESET_VALUE(`MFP_MONTH_RESET),
        .WRITE_MASK(`MFP_MONTH_MASK)
    ) u_alm1_month (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(wr_i && addr_i == `MFP_ADDR_ALM1_MONTH),
        .wdata_i(wdata_i),
        .value_o(alarm1_month_o)
    );

    // ==========================================================
    // control fields
    assign gp_level = q.ctrl[`MFP_CTRL_OUT];
    assign square_wave_enable = q.ctrl[`MFP_CTRL_SQUARE_WAVE_ENABLE];
    assign alarm1_enable = q.ctrl[`MFP_CTRL_ALARM1_ENABLE];
    assign alarm0_enable = q.ctrl[`MFP_CTRL_ALARM0_ENABLE];
    assign coarse_trim_enable = q.ctrl[`MFP_CTRL_COARSE_TRIM_ENABLE];
    assign square_wave_freq_select = q.ctrl[`MFP_CTRL_FS_HI:`MFP_CTRL_FS_LO];

    // ==========================================================
    // square wave source; held in reset on backup to save power
    sqw_divider #(.ONE_HZ_HALF(ONE_HZ_HALF)) u_div (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .osc_edge_i(osc_edge_i),
        .run_i(square_wave_enable && !on_backup_i),
        .coarse_i(coarse_trim_enable),
        .freq_sel_i(square_wave_freq_select),
        .sqw_o(sqw)
    );

    // ==========================================================
    // pin function and level
    always_comb begin
        if (square_wave_enable) begin
            mode = mfp_pkg::MODE_SQW;
        end else if (alarm0_enable || alarm1_enable) begin
            mode = mfp_pkg::MODE_ALARM;
        end else begin
            mode = mfp_pkg::MODE_GP;
        end

        if (alarm0_enable && alarm1_enable) begin
            alarm_level = alarm_polarity_i ? (alarm0_flag_i | alarm1_flag_i)
                                           : ~(alarm0_flag_i & alarm1_flag_i);
        end else if (alarm0_enable) begin
            alarm_level = alarm_polarity_i ? alarm0_flag_i : ~alarm0_flag_i;
        end else begin
            alarm_level = alarm_polarity_i ? alarm1_flag_i : ~alarm1_flag_i;
        end
        alarm_asserted = (mode == mfp_pkg::MODE_ALARM) && (alarm_level == alarm_polarity_i);

        unique case (mode)
            mfp_pkg::MODE_SQW: level = sqw;
            mfp_pkg::MODE_ALARM: level = alarm_level;
            mfp_pkg::MODE_GP: level = gp_level;
        endcase
        if (on_backup_i && mode != mfp_pkg::MODE_ALARM) begin
            level = 1'b1;
        end
    end

    // ==========================================================
    // register read mux
    always_comb begin
        unique case (addr_i)
            `MFP_ADDR_ALM0_DATE: read_mux = alarm0_date_o;
            `MFP_ADDR_ALM0_MONTH: read_mux = alarm0_month_o;
            `MFP_ADDR_ALM1_DATE: read_mux = alarm1_date_o;
            `MFP_ADDR_ALM1_MONTH: read_mux = alarm1_month_o;
            `MFP_ADDR_CONTROL: read_mux = q.ctrl;
            `MFP_ADDR_IRQ_STATUS: read_mux = {5'h00, q.irq_status};
            `MFP_ADDR_IRQ_ENABLE: read_mux = {5'h00, q.irq_enable};
            `MFP_ADDR_PIN_STATE: read_mux = {5'h00, 2'(mode), multi_function_pin_i};
            // the write-only clear register reads as zero
            default: read_mux = 8'h00;
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        d = q;
        events = '0;
        events[`MFP_IRQ_ALARM] = alarm_asserted && !q.alarm_prev;
        events[`MFP_IRQ_BK_ENTER] = on_backup_i && !q.backup_prev;
        events[`MFP_IRQ_BK_EXIT] = !on_backup_i && q.backup_prev;
        // edge detectors reset to the idle level, so the only event that can follow reset is an enter, raised if on_backup_i is already high
        d.alarm_prev = alarm_asserted;
        d.backup_prev = on_backup_i;
        d.rdata = rd_i ? read_mux : 8'h00;
        if (wr_i && addr_i == `MFP_ADDR_CONTROL) begin
            d.ctrl = wdata_i;
        end
        if (wr_i && addr_i == `MFP_ADDR_IRQ_ENABLE) begin
            d.irq_enable = wdata_i[`MFP_IRQ_W-1:0];
        end
        // a new event beats a clear written in the same cycle
        d.irq_status = q.irq_status | events;
        if (wr_i && addr_i == `MFP_ADDR_IRQ_CLEAR) begin
            d.irq_status = (q.irq_status & ~wdata_i[`MFP_IRQ_W-1:0]) | events;
        end
        d.pin_release = level;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    // open drain: output value is always low, only the enable moves
    assign multi_function_pin_o = 1'b0;
    assign multi_function_pin_oe_n_o = q.pin_release;
    assign rdata_o = q.rdata;
    assign irq_o = |(q.irq_status & q.irq_enable);

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    // register port
    date_store_a: assert property (
        wr_i && addr_i == `MFP_ADDR_ALM1_DATE |=> alarm1_date_o == ($past(wdata_i) & 8'h3F))
        else $error("date register did not store the digit fields");
    month_store_a: assert property (
        wr_i && addr_i == `MFP_ADDR_ALM0_MONTH |=> alarm0_month_o == ($past(wdata_i) & 8'h1F))
        else $error("month register did not store the digit fields");
    date_read_a: assert property (
        rd_i && addr_i == `MFP_ADDR_ALM0_DATE |=> rdata_o == $past(alarm0_date_o))
        else $error("alarm 0 date read wrong");
    month_read_a: assert property (
        rd_i && addr_i == `MFP_ADDR_ALM1_MONTH |=> rdata_o[7:5] == 3'h0 && rdata_o == $past(alarm1_month_o))
        else $error("alarm 1 month read wrong");
    date0_store_a: assert property (
        wr_i && addr_i == `MFP_ADDR_ALM0_DATE |=> alarm0_date_o == ($past(wdata_i) & 8'h3F))
        else $error("alarm 0 date register did not store");
    month1_store_a: assert property (
        wr_i && addr_i == `MFP_ADDR_ALM1_MONTH |=> alarm1_month_o == ($past(wdata_i) & 8'h1F))
        else $error("alarm 1 month register did not store");
    rdata_idle_a: assert property (
        !rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    pin_read_a: assert property (
        rd_i && addr_i == `MFP_ADDR_PIN_STATE |=> rdata_o[0] == $past(multi_function_pin_i))
        else $error("pin state read wrong");

    // pin function
    sqw_priority_a: assert property (
        square_wave_enable && !on_backup_i |=> multi_function_pin_oe_n_o == $past(sqw))
        else $error("square wave not on the pin");
    backup_quiet_a: assert property (
        on_backup_i && !alarm0_enable && !alarm1_enable |=> multi_function_pin_oe_n_o)
        else $error("pin driven on backup outside alarm mode");
    drive_low_a: assert property (
        !multi_function_pin_oe_n_o |-> multi_function_pin_o == 1'b0)
        else $error("pin driven high");
    gp_level_a: assert property (
        mode == mfp_pkg::MODE_GP && !on_backup_i |=> multi_function_pin_oe_n_o == $past(gp_level))
        else $error("general-purpose level not on the pin");
    single_alarm_a: assert property (
        !square_wave_enable && alarm0_enable && !alarm1_enable
        |=> multi_function_pin_oe_n_o == ($past(alarm0_flag_i) ~^ $past(alarm_polarity_i)))
        else $error("single alarm level wrong");
    dual_alarm_a: assert property (
        !square_wave_enable && alarm0_enable && alarm1_enable && !alarm_polarity_i
        && alarm0_flag_i && alarm1_flag_i |=> !multi_function_pin_oe_n_o)
        else $error("dual alarm low polarity did not assert");
    dual_high_a: assert property (
        !square_wave_enable && alarm0_enable && alarm1_enable && alarm_polarity_i
        |=> multi_function_pin_oe_n_o == $past(alarm0_flag_i | alarm1_flag_i))
        else $error("dual alarm high polarity is not the flag OR");
    square_backup_a: assert property (
        square_wave_enable && on_backup_i |=> multi_function_pin_oe_n_o)
        else $error("square wave reached the pin on backup");

    // interrupts
    irq_set_wins_a: assert property (
        events != 3'h0 |=> (q.irq_status & $past(events)) == $past(events))
        else $error("interrupt event lost");
    irq_clear_a: assert property (
        wr_i && addr_i == `MFP_ADDR_IRQ_CLEAR && events == 3'h0
        |=> (q.irq_status & $past(wdata_i[2:0])) == 3'h0)
        else $error("interrupt clear did not clear");

    sqw_mode_c: cover property (mode == mfp_pkg::MODE_SQW && $changed(sqw));
    alarm_mode_c: cover property (events[`MFP_IRQ_ALARM]);
    backup_c: cover property (on_backup_i && mode == mfp_pkg::MODE_ALARM);
    irq_c: cover property ($rose(irq_o));

endmodule : mfp_output_mux

`default_nettype wire

//--- dv/mfp_pull_host.sv
// Purpose: host side of the multi-function pin wire, with its pull-up resistor
// Assumes: the device only pulls the wire low or releases it
// Notes: the host may pull the wire low itself so that pin readback can be seen
`timescale 1ns/1ps
`default_nettype none

module mfp_pull_host (
    // device side
    input wire logic dev_level_i,
    input wire logic dev_oe_n_i,
    // host side
    input wire logic host_low_i,
    // wire level
    output logic pin_o
);
    // ==========================================================
    // wired-and with a pull-up: a released wire goes high, it never keeps an old value
    assign pin_o = (dev_oe_n_i ? 1'b1 : dev_level_i) & ~host_low_i;
endmodule : mfp_pull_host
`default_nettype wire

//--- dv/tb.sv
// Purpose: self-checking bench of the alarm compare registers and the pin mux
// Assumes: one 40 MHz clock, oscillator edge pulse every second cycle
// Notes: short 1 Hz half period keeps the run small
`include "mfp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam logic [15:0] HALF = 16'h0010;
    localparam logic [7:0] ADR [4] = '{`MFP_ADDR_ALM0_DATE, `MFP_ADDR_ALM0_MONTH,
                                       `MFP_ADDR_ALM1_DATE, `MFP_ADDR_ALM1_MONTH};
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic osc_edge_i = 1'b0;
    logic on_backup_i = 1'b0;
    logic [1:0] flag_i = 2'b00;
    logic pol_i = 1'b0;
    logic host_low = 1'b0;
    logic osc_run = 1'b0;
    logic [7:0] rdata_o, a0d, a0m, a1d, a1m;
    logic pin_drv, pin_oe_n, irq_o, pin_wire;
    logic [7:0] rnd = 8'h45;
    int failures = 0;
    int checks_done = 0;

    always #12.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) osc_edge_i <= osc_run & ~osc_edge_i;

    mfp_output_mux #(.ONE_HZ_HALF(HALF)) DUT (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .osc_edge_i(osc_edge_i),
        .on_backup_i(on_backup_i), .alarm0_flag_i(flag_i[0]), .alarm1_flag_i(flag_i[1]),
        .alarm_polarity_i(pol_i), .alarm0_date_o(a0d), .alarm0_month_o(a0m),
        .alarm1_date_o(a1d), .alarm1_month_o(a1m), .multi_function_pin_i(pin_wire),
        .multi_function_pin_o(pin_drv), .multi_function_pin_oe_n_o(pin_oe_n), .irq_o(irq_o));

    mfp_pull_host HOST (.dev_level_i(pin_drv), .dev_oe_n_i(pin_oe_n),
                        .host_low_i(host_low), .pin_o(pin_wire));

    // ==========================================================
    // expectations
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    function automatic logic alarm_level(input logic [1:0] en, input logic pol,
                                         input logic [1:0] f);
        if (en == 2'b11) return pol ? |f : ~&f;
        return pol ? f[en[1]] : ~f[en[1]];
    endfunction : alarm_level

    // ==========================================================
    // bus, pin and report tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        chk(what, {8'h00, exp}, {8'h00, rdata_o});
    endtask : rd_chk

    task automatic settle;
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask : settle

    task automatic drive(input logic bk, input logic pol, input logic [1:0] f);
        @(posedge clk_sys_i);
        on_backup_i <= bk;
        pol_i <= pol;
        flag_i <= f;
        settle();
    endtask : drive

    // cycles between the first and second level change of the wire
    task automatic half_period(output int n);
        logic last;
        repeat (2) begin
            last = pin_wire;
            n = 0;
            while (pin_wire === last && n < 3000) begin
                @(posedge clk_sys_i);
                #1;
                n++;
            end
        end
    endtask : half_period

    task automatic give_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    // watchdog: the whole sequence needs well under 20000 cycles
    initial begin
        #1000000;
        failures++;
        give_verdict();
    end

    // ==========================================================
    // tests
    initial begin
        int n;
        int exp;
        repeat (8) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        osc_run <= 1'b1;
        for (int i = 0; i < 4; i++) rd_chk("match reset", ADR[i], 8'h01);
        rd_chk("control reset", `MFP_ADDR_CONTROL, `MFP_CTRL_RESET);
        rd_chk("irq status reset", `MFP_ADDR_IRQ_STATUS, 8'h00);
        chk("pin at reset", 16'h0001, {15'h0, pin_wire});
        $display("test reset done");

        for (int k = 0; k < 6; k++) begin
            for (int i = 0; i < 4; i++) begin
                rnd = lfsr_next(rnd);
                wr_reg(ADR[i], rnd);
                exp = rnd & (i[0] ? `MFP_MONTH_MASK : `MFP_DATE_MASK);
                rd_chk("match readback", ADR[i], exp[7:0]);
            end
        end
        wr_reg(ADR[0], 8'hFF);
        wr_reg(ADR[1], 8'hFF);
        wr_reg(ADR[2], 8'h29);
        wr_reg(ADR[3], 8'h12);
        settle();
        chk("alarm0 compare", 16'h3F1F, {a0d, a0m});
        chk("alarm1 compare", 16'h2912, {a1d, a1m});
        wr_reg(8'h30, rnd);
        rd_chk("unmapped", 8'h30, 8'h00);
        rnd = lfsr_next(rnd);
        wr_reg(`MFP_ADDR_CONTROL, rnd);
        rd_chk("control readback", `MFP_ADDR_CONTROL, rnd);
        $display("test registers done");

        wr_reg(`MFP_ADDR_CONTROL, 8'h00);
        settle();
        chk("gp low", 16'h0000, {15'h0, pin_wire});
        chk("drive value", 16'h0000, {15'h0, pin_drv});
        drive(1'b1, 1'b0, 2'b00);
        chk("gp on backup", 16'h0001, {15'h0, pin_wire});
        drive(1'b0, 1'b0, 2'b00);
        wr_reg(`MFP_ADDR_CONTROL, 8'h80);
        settle();
        chk("gp high", 16'h0001, {15'h0, pin_wire});
        @(posedge clk_sys_i) host_low <= 1'b1;
        settle();
        rd_chk("pin state low", `MFP_ADDR_PIN_STATE, 8'h00);
        @(posedge clk_sys_i) host_low <= 1'b0;
        settle();
        rd_chk("pin state high", `MFP_ADDR_PIN_STATE, 8'h01);
        $display("test general purpose done");

        for (int e = 1; e < 4; e++) begin
            rnd = lfsr_next(rnd);
            wr_reg(`MFP_ADDR_CONTROL, {rnd[7], 1'b0, e[1:0], 4'h0});
            for (int v = 0; v < 8; v++) begin
                drive(1'b0, v[2], v[1:0]);
                chk("alarm pin", {15'h0, alarm_level(e[1:0], v[2], v[1:0])},
                    {15'h0, pin_wire});
            end
        end
        drive(1'b1, 1'b1, 2'b00);
        chk("alarm on backup low", 16'h0000, {15'h0, pin_wire});
        drive(1'b1, 1'b1, 2'b10);
        chk("alarm on backup high", 16'h0001, {15'h0, pin_wire});
        drive(1'b0, 1'b0, 2'b00);
        $display("test alarm done");

        for (int f = 0; f < 5; f++) begin
            wr_reg(`MFP_ADDR_CONTROL, 8'h00);
            wr_reg(`MFP_ADDR_CONTROL, f == 4 ? 8'h76 : {6'b011100, f[1:0]});
            exp = f == 4 ? 512 : f == 3 ? 1 : f == 2 ? 4 : f == 1 ? 8 : int'(HALF);
            half_period(n);
            chk("square half period", 16'(2 * exp), 16'(n));
        end
        wr_reg(`MFP_ADDR_CONTROL, 8'h00);
        wr_reg(`MFP_ADDR_CONTROL, 8'h43);
        drive(1'b1, 1'b0, 2'b00);
        n = 0;
        repeat (40) begin
            @(posedge clk_sys_i);
            #1;
            n += (pin_wire !== 1'b1);
        end
        chk("square on backup", 16'h0000, 16'(n));
        drive(1'b0, 1'b0, 2'b00);
        $display("test square wave done");

        wr_reg(`MFP_ADDR_CONTROL, 8'h10);
        drive(1'b0, 1'b1, 2'b00);
        wr_reg(`MFP_ADDR_IRQ_CLEAR, 8'h07);
        wr_reg(`MFP_ADDR_IRQ_ENABLE, 8'h01);
        settle();
        chk("irq idle", 16'h0000, {15'h0, irq_o});
        drive(1'b0, 1'b1, 2'b01);
        chk("irq raised", 16'h0001, {15'h0, irq_o});
        rd_chk("irq status alarm", `MFP_ADDR_IRQ_STATUS, 8'h01);
        wr_reg(`MFP_ADDR_IRQ_CLEAR, 8'h01);
        settle();
        chk("irq cleared", 16'h0000, {15'h0, irq_o});
        wr_reg(`MFP_ADDR_IRQ_ENABLE, 8'h00);
        drive(1'b0, 1'b1, 2'b00);
        drive(1'b0, 1'b1, 2'b01);
        chk("irq masked", 16'h0000, {15'h0, irq_o});
        rd_chk("irq status masked", `MFP_ADDR_IRQ_STATUS, 8'h01);
        wr_reg(`MFP_ADDR_IRQ_CLEAR, 8'h07);
        wr_reg(`MFP_ADDR_IRQ_ENABLE, 8'h06);
        drive(1'b1, 1'b1, 2'b01);
        chk("irq backup enter", 16'h0001, {15'h0, irq_o});
        rd_chk("irq status enter", `MFP_ADDR_IRQ_STATUS, 8'h02);
        drive(1'b0, 1'b1, 2'b01);
        rd_chk("irq status exit", `MFP_ADDR_IRQ_STATUS, 8'h06);
        $display("test interrupt done");
        give_verdict();
    end
endmodule : tb
`default_nettype wire
